// ===== hw/sfp_pkg.sv
/*
 * Constants for the host-side controller of a byte-wide sector flash.
 * Assumes a 250 MHz system clock and the flash wired directly to the pins.
 */
// What this block does
// - Host loads only the bytes it is given; unloaded bytes become indeterminate.
// - Host sends the same three unlock commands before every program operation.
// - Host loads bytes by strobe pulses with output gate held high.
// - Next load starts within 150 us, else device begins programming.
// - Upper lines pick the sector, lower lines the byte; any load order.
package sfp_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int SECTOR_BYTES = 256;
   localparam int CLK_MHZ = 250;
   // strobe low time kept well above the noise filter width
   localparam int STROBE_NS = 60;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   // setup and recovery phases around each strobe
   localparam int SETUP_NS = 20;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_NS = 120;
   localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
   localparam int LOAD_WIN_US = 150;
   localparam int LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ;
   localparam int PROG_MS = 20;
   localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
   localparam int CMD_MAX = 7;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROG = 2'h1;
   localparam logic [1:0] OP_CMD = 2'h2;
   localparam logic [DATA_W-1:0] ID_UNLOCKED = 8'hFE;
   localparam logic [DATA_W-1:0] ID_LOCKED = 8'hFF;
   localparam logic [ADDR_W-1:0] LOW_BOOT_ID_ADDR = 18'h00002;
   localparam logic [ADDR_W-1:0] HIGH_BOOT_ID_ADDR = 18'h3FFF2;
   typedef enum logic [6:0] {
      SFP_IDLE = 7'h01,
      SFP_SETUP = 7'h02,
      SFP_STROBE = 7'h04,
      SFP_HOLD = 7'h08,
      SFP_READ = 7'h10,
      SFP_POLL = 7'h20,
      SFP_DONE = 7'h40
   } sfp_state_e;
endpackage : sfp_pkg

// ===== hw/sfp_host.sv
/*
 * Host controller that reads, sector-programs and sends command sequences
 * to a byte-wide parallel flash. Assumes the flash pins are wired straight
 * to this module and the bench resolves the data bus from data_oe_o.
 */
`timescale 1ns/1ps
module sfp_host #(
   parameter int LOAD_WIN_CYCLES = sfp_pkg::LOAD_WIN_CYC,
   parameter int PROG_CYCLES = sfp_pkg::PROG_CYC,
   parameter logic [3*sfp_pkg::ADDR_W-1:0] UNLOCK_ADDR = {18'h05555, 18'h02AAA, 18'h05555},
   parameter logic [3*sfp_pkg::DATA_W-1:0] UNLOCK_DATA = {8'hA0, 8'h55, 8'hAA}
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [1:0] req_op_i,
   input wire logic [sfp_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [sfp_pkg::DATA_W-1:0] req_data_i,
   input wire logic req_last_i,
   output logic rsp_valid_o,
   output logic [sfp_pkg::DATA_W-1:0] rsp_data_o,
   output logic rsp_timeout_o,
   output logic busy_o,
   output logic [sfp_pkg::ADDR_W-1:0] flash_addr_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   input wire logic [sfp_pkg::DATA_W-1:0] flash_data_i,
   output logic [sfp_pkg::DATA_W-1:0] flash_data_o,
   output logic data_oe_o
);
   import sfp_pkg::*;

   initial begin
      if (LOAD_WIN_CYCLES < 64 || PROG_CYCLES < 2 || LOAD_WIN_CYCLES > PROG_CYCLES) begin
         $error("sfp_host: timing parameters too small");
      end
   end

   localparam int CW = $clog2(PROG_CYCLES + 1);

   sfp_state_e state, next_state;
   logic [CW-1:0] cnt, next_cnt, prog_cnt, next_prog_cnt, win_cnt, next_win_cnt;
   logic [1:0] op, next_op;
   logic [2:0] useq, next_useq;
   logic [4:0] we_low_cnt, next_we_low_cnt;
   logic in_sector, next_in_sector;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [DATA_W-1:0] wdata, next_wdata, poll_prev, next_poll_prev, rdata, next_rdata;
   logic rvalid, next_rvalid, tout, next_tout, last, next_last, poll_first, next_poll_first;
   logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n, doe, next_doe;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_op = op;
      next_useq = useq;
      next_in_sector = in_sector;
      next_addr = addr;
      next_wdata = wdata;
      next_last = last;
      next_poll_prev = poll_prev;
      next_poll_first = poll_first;
      next_prog_cnt = prog_cnt;
      next_win_cnt = win_cnt;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      next_tout = tout;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_doe = doe;
      next_we_low_cnt = we_n ? 5'h00 : we_low_cnt + {4'h0, we_low_cnt != 5'h1F};
      // load window measured from the end of the hold phase after the last strobe
      if (in_sector && state == SFP_IDLE) begin
         next_win_cnt = win_cnt + CW'(1);
      end
      unique case (state)
         SFP_IDLE: begin
            if (req_valid_i) begin
               next_op = req_op_i;
               next_addr = req_addr_i;
               next_wdata = req_data_i;
               next_last = req_last_i;
               next_cnt = '0;
               next_tout = 1'b0;
               if (req_op_i == OP_READ) begin
                  next_state = SFP_READ;
                  next_ce_n = 1'b0;
                  next_oe_n = 1'b0;
               end else begin
                  // command bytes go out raw, one per request
                  // unlock prefix on the first byte of a sector
                  next_useq = (req_op_i == OP_PROG && !in_sector) ? 3'h0 : 3'h3;
                  next_state = SFP_SETUP;
                  next_oe_n = 1'b1;
               end
            end
         end
         SFP_SETUP: begin
            next_ce_n = 1'b0;
            next_doe = 1'b1;
            next_cnt = cnt + CW'(1);
            if (cnt == CW'(SETUP_CYC - 1)) begin
               next_cnt = '0;
               next_state = SFP_STROBE;
               // write strobe pulse with output gate high
               next_we_n = 1'b0;
            end
         end
         SFP_STROBE: begin
            next_cnt = cnt + CW'(1);
            // pulse long enough to pass the noise filter
            if (cnt == CW'(STROBE_CYC - 1)) begin
               next_cnt = '0;
               next_we_n = 1'b1;
               next_state = SFP_HOLD;
            end
         end
         SFP_HOLD: begin
            next_cnt = cnt + CW'(1);
            if (cnt == CW'(SETUP_CYC - 1)) begin
               next_cnt = '0;
               next_doe = 1'b0;
               next_ce_n = 1'b1;
               next_win_cnt = '0;
               if (useq < 3'h2) begin
                  next_useq = useq + 3'h1;
                  next_state = SFP_SETUP;
               end else if (useq == 3'h2) begin
                  next_useq = 3'h3;
                  next_state = SFP_SETUP;
                  next_in_sector = 1'b1;
               end else if (last || op == OP_CMD) begin
                  // caller flags the final byte it loads, whether or not the sector is full
                  // poll on the last byte loaded
                  next_state = SFP_POLL;
                  next_in_sector = 1'b0;
                  next_poll_first = 1'b1;
                  next_prog_cnt = '0;
                  next_ce_n = 1'b0;
                  next_oe_n = 1'b0;
               end else begin
                  next_state = SFP_IDLE;
               end
            end
         end
         SFP_READ: begin
            next_cnt = cnt + CW'(1);
            if (cnt == CW'(READ_CYC - 1)) begin
               next_rdata = flash_data_i;
               next_rvalid = 1'b1;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_state = SFP_DONE;
            end
         end
         SFP_POLL: begin
            next_cnt = cnt + CW'(1);
            next_prog_cnt = prog_cnt + CW'(1);
            if (cnt == CW'(READ_CYC - 1)) begin
               next_cnt = '0;
               next_poll_prev = flash_data_i;
               next_poll_first = 1'b0;
               next_oe_n = 1'b1;
               // done when the toggle bit stops and bit 7 matches the written data
               if (!poll_first && flash_data_i[6] == poll_prev[6] && flash_data_i[7] == wdata[7]) begin
                  next_state = SFP_DONE;
                  next_rvalid = 1'b1;
                  next_rdata = flash_data_i;
                  next_ce_n = 1'b1;
               end
            end else if (cnt == CW'(1)) begin
               next_oe_n = 1'b0;
            end
            // give up after the longest program time
            if (prog_cnt >= CW'(PROG_CYCLES)) begin
               next_state = SFP_DONE;
               next_tout = 1'b1;
               next_rvalid = 1'b1;
               next_rdata = flash_data_i;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
            end
         end
         SFP_DONE: begin
            next_state = SFP_IDLE;
         end
         default: begin
            next_state = SFP_IDLE;
         end
      endcase
      if (in_sector && state == SFP_IDLE && !req_valid_i && win_cnt >= CW'(LOAD_WIN_CYCLES - 32)) begin
         // no request 32 cycles before the window closes; device will program, so poll
         next_state = SFP_POLL;
         next_in_sector = 1'b0;
         next_poll_first = 1'b1;
         next_prog_cnt = '0;
         next_cnt = '0;
         next_ce_n = 1'b0;
         next_oe_n = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= SFP_IDLE;
         cnt <= '0;
         op <= OP_READ;
         useq <= 3'h3;
         in_sector <= 1'b0;
         addr <= '0;
         wdata <= '0;
         last <= 1'b0;
         poll_prev <= '0;
         poll_first <= 1'b1;
         prog_cnt <= '0;
         win_cnt <= '0;
         rdata <= '0;
         rvalid <= 1'b0;
         tout <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         doe <= 1'b0;
         we_low_cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         op <= next_op;
         useq <= next_useq;
         in_sector <= next_in_sector;
         addr <= next_addr;
         wdata <= next_wdata;
         last <= next_last;
         poll_prev <= next_poll_prev;
         poll_first <= next_poll_first;
         prog_cnt <= next_prog_cnt;
         win_cnt <= next_win_cnt;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         tout <= next_tout;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         doe <= next_doe;
         we_low_cnt <= next_we_low_cnt;
      end
   end

   // address: unlock steps use the parameter table
   assign flash_addr_o = (useq < 3'h3) ? UNLOCK_ADDR[useq*ADDR_W +: ADDR_W] : addr;
   assign flash_data_o = (useq < 3'h3) ? UNLOCK_DATA[useq*DATA_W +: DATA_W] : wdata;
   assign flash_ce_n_o = ce_n;
   assign flash_oe_n_o = oe_n;
   assign flash_we_n_o = we_n;
   assign data_oe_o = doe;
   assign req_ready_o = (state == SFP_IDLE);
   assign busy_o = (state != SFP_IDLE);
   assign rsp_valid_o = rvalid;
   assign rsp_data_o = rdata;
   assign rsp_timeout_o = tout;

   // output gate high whenever data is driven
   AST_OE_WHILE_DRIVE: assert property (@(posedge clk_i) disable iff (srst_i) data_oe_o |-> flash_oe_n_o)
      else $error("data driven with output gate low");
   // strobe only with chip select low
   AST_WE_WITH_CE: assert property (@(posedge clk_i) disable iff (srst_i) !flash_we_n_o |-> !flash_ce_n_o && data_oe_o)
      else $error("write strobe without chip select");
   AST_STROBE_WIDTH: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(flash_we_n_o) |-> we_low_cnt >= 5'(STROBE_CYC))
      else $error("write strobe too short");
   // a fresh sector starts with the unlock step
   AST_UNLOCK_FIRST: assert property (@(posedge clk_i) disable iff (srst_i)
      (state == SFP_IDLE && req_valid_i && req_op_i == OP_PROG && !in_sector) |=> useq == 3'h0)
      else $error("program without unlock");
   // next strobe or polling before the window closes
   AST_LOAD_WINDOW: assert property (@(posedge clk_i) disable iff (srst_i)
      in_sector |-> win_cnt < CW'(LOAD_WIN_CYCLES))
      else $error("load window overrun");
   AST_POLL_BOUND: assert property (@(posedge clk_i) disable iff (srst_i)
      state == SFP_POLL |-> prog_cnt <= CW'(PROG_CYCLES))
      else $error("poll exceeded program time");
   // no completion on the first poll read
   AST_POLL_TWO_READS: assert property (@(posedge clk_i) disable iff (srst_i)
      ($past(state) == SFP_POLL && state == SFP_DONE && !tout) |-> !$past(poll_first))
      else $error("completion without toggle compare");
   // read answers after the access time
   AST_READ_LAT: assert property (@(posedge clk_i) disable iff (srst_i)
      (state == SFP_IDLE && req_valid_i && req_op_i == OP_READ) |-> ##31 rsp_valid_o)
      else $error("read answer late");
   COV_READ: cover property (@(posedge clk_i) disable iff (srst_i) rsp_valid_o && op == OP_READ);
   COV_PROG_DONE: cover property (@(posedge clk_i) disable iff (srst_i) rsp_valid_o && op == OP_PROG && !tout);
   COV_WINDOW_END: cover property (@(posedge clk_i) disable iff (srst_i) in_sector && !next_in_sector && state == SFP_IDLE);
   COV_CMD: cover property (@(posedge clk_i) disable iff (srst_i) rsp_valid_o && op == OP_CMD);
endmodule : sfp_host

// ===== verification/sfp_flash_model.sv
/* Behavioural sector flash for the host bench.
   Assumes strobes move only on clk edges; timers count clk cycles. */
`timescale 1ns/1ps
module sfp_flash_model #(
   parameter int WIN_CYC = 200,
   parameter int PROG_CYC = 500,
   parameter logic [53:0] UA = {18'h05555, 18'h02AAA, 18'h05555},
   parameter logic [23:0] UD = {8'hA0, 8'h55, 8'hAA}
) (
   input wire logic clk_i,
   input wire logic [17:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic dq_oe_o
);
   logic [7:0] mem [int];
   logic [7:0] lat [256];
   logic [255:0] vld = '0;
   logic [17:0] cap = '0;
   logic [17:0] last_a = '0;
   logic [7:0] last_d = 8'h00;
   logic prev_w = 1'b1;
   logic prev_o = 1'b1;
   logic loading = 1'b0;
   logic busy = 1'b0;
   logic tog = 1'b0;
   int unl = 0;
   int low = 0;
   int cnt = 0;
   wire logic wr_n = ce_n_i | we_n_i;
   // erase, lockout and id modes not modelled; blank reads FF
   function automatic logic [7:0] rd(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : rd
   assign dq_oe_o = !ce_n_i && !oe_n_i && we_n_i;
   always @(posedge clk_i) begin
      dq_o <= busy ? {~last_d[7], tog, last_d[5:0]} : rd(addr_i);
      prev_w <= wr_n;
      prev_o <= oe_n_i;
      if (prev_o && !oe_n_i && !ce_n_i && busy) tog <= ~tog;
      if (prev_w && !wr_n) begin
         cap <= addr_i;
         low <= 0;
      end else if (!wr_n) low <= low + 1;
      if (!prev_w && wr_n && oe_n_i && low >= 3 && !busy) begin
         if (loading) begin
            lat[cap[7:0]] <= dq_i;
            vld[cap[7:0]] <= 1'b1;
            cnt <= 0;
            last_a <= cap;
            last_d <= dq_i;
         end else if (cap == UA[unl*18 +: 18] && dq_i == UD[unl*8 +: 8]) begin
            unl <= (unl == 2) ? 0 : unl + 1;
            loading <= (unl == 2);
            vld <= '0;
            cnt <= 0;
         end else begin
            busy <= 1'b1;
            cnt <= 0;
            unl <= 0;
            last_d <= dq_i;
         end
      end else if (loading && wr_n) begin
         cnt <= cnt + 1;
         if (cnt == WIN_CYC) begin
            loading <= 1'b0;
            busy <= 1'b1;
            cnt <= 0;
            for (int i = 0; i < 256; i++) mem[{last_a[17:8], i[7:0]}] = vld[i] ? lat[i] : 8'hXX;
         end
      end else if (busy) begin
         cnt <= cnt + 1;
         if (cnt == PROG_CYC) busy <= 1'b0;
      end
   end
endmodule : sfp_flash_model

// ===== verification/tb_sfp_host.sv
/* Self-checking bench for sfp_host against a behavioural flash.
   Assumes shortened load window and poll limit to keep runs short. */
`timescale 1ns/1ps
module tb_sfp_host;
   import sfp_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_last_i = 1'b0;
   logic [1:0] req_op_i = 2'h0;
   logic [ADDR_W-1:0] req_addr_i = '0;
   logic [DATA_W-1:0] req_data_i = '0;
   logic req_ready_o, rsp_valid_o, rsp_timeout_o, busy_o, ce_n, oe_n, we_n, data_oe_o, f_oe;
   logic [DATA_W-1:0] rsp_data_o, flash_data_o, f_dq, bus;
   logic [DATA_W-1:0] last_bus = 8'h00;
   logic [ADDR_W-1:0] flash_addr_o;
   logic [7:0] offs [3] = '{8'h07, 8'h02, 8'h05};
   int err_count = 0;
   int n_compared = 0;
   // released bus shows the inverse of its last level
   assign bus = data_oe_o ? flash_data_o : (f_oe ? f_dq : ~last_bus);
   always @(posedge clk_i) last_bus <= bus;
   sfp_host #(.LOAD_WIN_CYCLES(200), .PROG_CYCLES(2000)) i_sfp_host (.clk_i(clk_i), .srst_i(srst_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
      .req_data_i(req_data_i), .req_last_i(req_last_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .rsp_timeout_o(rsp_timeout_o), .busy_o(busy_o), .flash_addr_o(flash_addr_o), .flash_ce_n_o(ce_n),
      .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_data_i(bus), .flash_data_o(flash_data_o),
      .data_oe_o(data_oe_o));
   sfp_flash_model i_sfp_flash_model (.clk_i(clk_i), .addr_i(flash_addr_o), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .dq_i(bus), .dq_o(f_dq), .dq_oe_o(f_oe));
   initial forever #2 clk_i = ~clk_i;
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic send(input logic [1:0] op, input logic [17:0] a, input logic [7:0] d, input logic last);
      @(negedge clk_i);
      for (int n = 0; req_ready_o !== 1'b1; n++) begin
         if (n > 5000) begin
            check("ready wait", 8'h01, 8'h00);
            give_verdict();
         end
         @(negedge clk_i);
      end
      req_valid_i = 1'b1;
      req_op_i = op;
      req_addr_i = a;
      req_data_i = d;
      req_last_i = last;
      @(negedge clk_i);
      req_valid_i = 1'b0;
   endtask : send
   task automatic wait_rsp(output logic [7:0] d);
      for (int n = 0; rsp_valid_o !== 1'b1; n++) begin
         if (n > 3000) begin
            check("response wait", 8'h01, 8'h00);
            give_verdict();
         end
         @(negedge clk_i);
      end
      d = rsp_data_o;
   endtask : wait_rsp
   task automatic read_chk(input logic [17:0] a, input logic [7:0] exp);
      logic [7:0] d;
      send(OP_READ, a, 8'h00, 1'b0);
      wait_rsp(d);
      check("read data", exp, d);
   endtask : read_chk
   task automatic t_reset();
      check("strobes idle", 8'h07, {5'h0, ce_n, oe_n, we_n});
      check("bus released", 8'h00, {7'h0, data_oe_o});
      check("ready", 8'h01, {7'h0, req_ready_o});
      check("busy idle", 8'h00, {7'h0, busy_o});
      $display("test reset done");
   endtask : t_reset
   task automatic t_program(input logic [7:0] base);
      logic [7:0] d;
      for (int i = 0; i < 3; i++) send(OP_PROG, {10'h005, offs[i]}, base + offs[i], i == 2);
      wait_rsp(d);
      check("timeout flag", 8'h00, {7'h0, rsp_timeout_o});
      for (int i = 0; i < 3; i++) read_chk({10'h005, offs[i]}, base + offs[i]);
      $display("test program done");
   endtask : t_program
   task automatic t_unprot();
      logic [7:0] d;
      send(OP_CMD, 18'h01234, 8'h92, 1'b1);
      check("busy", 8'h01, {7'h0, busy_o});
      wait_rsp(d);
      check("timeout flag", 8'h00, {7'h0, rsp_timeout_o});
      read_chk(18'h01234, 8'hFF);
      $display("test unprotected write done");
   endtask : t_unprot
   task automatic t_window();
      logic [7:0] d;
      send(OP_PROG, 18'h00603, 8'h3C, 1'b0);
      send(OP_PROG, 18'h00609, 8'h4A, 1'b0);
      wait_rsp(d);
      check("timeout flag", 8'h00, {7'h0, rsp_timeout_o});
      read_chk(18'h00603, 8'h3C);
      read_chk(18'h00609, 8'h4A);
      $display("test window end done");
   endtask : t_window
   always @(posedge clk_i) begin
      if (!srst_i && !we_n && oe_n !== 1'b1) check("gate during load", 8'h01, 8'h00);
      if (!srst_i && data_oe_o && !oe_n) check("bus contention", 8'h00, 8'h01);
   end
   initial begin
      #200000;
      check("watchdog", 8'h00, 8'h01);
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      srst_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      read_chk(18'h00123, 8'hFF);
      t_program(8'h10);
      t_program(8'hC0);
      t_unprot();
      t_window();
      give_verdict();
   end
endmodule : tb_sfp_host
